// ===== por_device.sv
`timescale 1ns/1ps
// Purpose: module-side power-on / reset sequencer
// Assumes: switch-on and reset requests arrive as pulled-up open-drain lines
// Notes:   one clock; long counts are parameters so simulation can shorten them
//          both request lines share one meter design, one instance per line
//          the working memory is a stand-in that only the reset wipe writes
module por_device #(
  parameter int unsigned ON_ASSERT_CYC  = por_seq_pkg::ON_ASSERT_CYC,
  parameter int unsigned RST_ASSERT_CYC = por_seq_pkg::RST_ASSERT_CYC,
  parameter int unsigned POWER_UP_CYC   = por_seq_pkg::POWER_UP_CYC,
  parameter int unsigned RAM_DEPTH      = 16,
  parameter int unsigned RAM_W          = 8
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // link
  por_link_if.device link,
  // module-side user port
  input  wire logic software_power_off_command,
  output logic      module_ready,
  output logic      wipe_busy
);

  // ************************************************************
  // parameter checks
  // ************************************************************
  // the power-up count starts preloaded with the width just measured,
  // so the power-up period must be the longer of the two
  initial begin
    if (ON_ASSERT_CYC < 1 || RST_ASSERT_CYC < 1) begin
      $error("por_device: assertion widths must be at least one cycle");
    end
    if (POWER_UP_CYC <= ON_ASSERT_CYC || POWER_UP_CYC <= RST_ASSERT_CYC) begin
      $error("por_device: power-up period must exceed both assertion widths");
    end
    if (RAM_DEPTH < 1 || RAM_W < 1) begin
      $error("por_device: working memory needs at least one word of one bit");
    end
    if (POWER_UP_CYC == 32'hFFFF_FFFF) begin
      $error("por_device: power-up period leaves the counter no headroom");
    end
  end

  // a one-word memory still needs a one-bit address
  localparam int AW = (RAM_DEPTH > 1) ? $clog2(RAM_DEPTH) : 1;

  // ************************************************************
  // request meters
  // ************************************************************
  // index 0 is the switch-on line, index 1 the reset line
  logic [1:0] line_n;
  logic [1:0] line_low;
  logic [1:0] line_acc;
  logic       on_low;
  logic       on_acc;
  logic       rst_acc;

  assign line_n = {link.reset_request_n, link.switch_on_request_n};

  // a released line is seen high through the link pull-up, so idle means no request;
  // the falling-edge output stays open because the count is preloaded instead
  for (genvar i = 0; i < 2; i++) begin : g_meter
    low_width_meter #(
      .MIN_CYC ((i == 0) ? ON_ASSERT_CYC : RST_ASSERT_CYC)
    ) u_meter (
      .clk      (clk),
      .rst_n    (rst_n),
      .req_n    (line_n[i]),
      .low      (line_low[i]),
      .fall     (),
      .accepted (line_acc[i])
    );
  end

  // a reset line that is low but not yet accepted changes nothing
  assign on_low  = line_low[0];
  assign on_acc  = line_acc[0];
  assign rst_acc = line_acc[1];

  // ************************************************************
  // sequencer state
  // ************************************************************
  typedef struct packed {
    por_seq_pkg::mod_state_e       state;
    logic [por_seq_pkg::CNT_W-1:0] up_cnt;
    logic [AW-1:0]                 wipe_addr;
    logic                          wiping;
    logic                          on_ind;
  } dev_s;

  dev_s st_ff;
  dev_s nxt_st;

  // stand-in for processor registers and working memory that a reset must clear
  logic [RAM_W-1:0] work_ram [RAM_DEPTH];

  // ************************************************************
  // next-state logic
  // ************************************************************
  // up_cnt counts cycles since the synchronised fall of the accepted request;
  // the preload makes up for the cycles spent measuring its width
  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff.state)
      por_seq_pkg::ST_OFF: begin
        // the count idles while off; only the preload on acceptance matters
        nxt_st.up_cnt = por_seq_pkg::CNT_W'(1);
        // the width check lags the fall by ON_ASSERT_CYC, so start counting from the fall
        if (on_acc) begin
          nxt_st.state  = por_seq_pkg::ST_POWER_UP;
          nxt_st.up_cnt = por_seq_pkg::CNT_W'(ON_ASSERT_CYC) + 1'b1;
        end
      end
      por_seq_pkg::ST_POWER_UP, por_seq_pkg::ST_RESTART: begin
        // a restart may not finish while words are still being cleared
        nxt_st.up_cnt = st_ff.up_cnt + 1'b1;
        if (st_ff.up_cnt >= por_seq_pkg::CNT_W'(POWER_UP_CYC) && !st_ff.wiping) begin
          nxt_st.state = por_seq_pkg::ST_ON;
        end
      end
      por_seq_pkg::ST_ON: begin
        // a switch-on request here is simply ignored
        nxt_st.up_cnt = '0;
        if (software_power_off_command) begin
          nxt_st.state = por_seq_pkg::ST_OFF;
        end
      end
      // only a corrupted state code lands here
      default: nxt_st.state = por_seq_pkg::ST_OFF;
    endcase

    // a valid reset overrides everything else; the switch-on level seen in the
    // accepting cycle picks restart or power-off, and a wipe in progress starts over
    if (rst_acc) begin
      nxt_st.wiping    = 1'b1;
      nxt_st.wipe_addr = '0;
      if (on_low) begin
        nxt_st.state  = por_seq_pkg::ST_RESTART;
        nxt_st.up_cnt = por_seq_pkg::CNT_W'(RST_ASSERT_CYC) + 1'b1;
      end else begin
        nxt_st.state = por_seq_pkg::ST_OFF;
      end
    end else if (st_ff.wiping) begin
      // one word per cycle; the last address ends the wipe
      nxt_st.wipe_addr = st_ff.wipe_addr + 1'b1;
      if (st_ff.wipe_addr == AW'(RAM_DEPTH - 1)) begin
        nxt_st.wiping = 1'b0;
      end
    end

    // decoded from the next state so the indicator moves with the state
    nxt_st.on_ind = (nxt_st.state == por_seq_pkg::ST_ON) ||
                    (nxt_st.state == por_seq_pkg::ST_POWER_UP);
  end

  // ************************************************************
  // state update
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '{state: por_seq_pkg::ST_OFF, up_cnt: '0, wipe_addr: '0,
                 wiping: 1'b0, on_ind: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ************************************************************
  // working memory clear
  // ************************************************************
  // one word per cycle keeps the clear to a single write port; the cost is
  // RAM_DEPTH cycles before a restart may finish, well inside the power-up period;
  // the memory has no reset branch on purpose, only the wipe ever writes it
  always_ff @(posedge clk) begin
    if (st_ff.wiping) begin
      work_ram[st_ff.wipe_addr] <= '0;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  // the indicator comes straight from a flop so the pin never glitches
  assign link.module_on_indicator = st_ff.on_ind;
  // ready is narrower than the indicator: it excludes the power-up wait
  assign module_ready             = (st_ff.state == por_seq_pkg::ST_ON);
  // high for RAM_DEPTH cycles after each accepted reset
  assign wipe_busy                = st_ff.wiping;

endmodule : por_device

// ===== por_seq_pkg.sv
// Purpose: shared constants and types for the power-on and reset sequencer pair
// Assumes: 200 MHz clock
// Notes:   times are kept in milliseconds, cycle counts are derived from them
package por_seq_pkg;

  localparam int unsigned CLK_HZ         = 200_000_000;
  localparam int unsigned CYC_PER_MS     = CLK_HZ / 1000;
  localparam int unsigned ON_ASSERT_MS   = 25;
  localparam int unsigned RST_ASSERT_MS  = 20;
  localparam int unsigned POWER_UP_MS    = 2000;
  localparam int unsigned ON_ASSERT_CYC  = ON_ASSERT_MS * CYC_PER_MS;
  localparam int unsigned RST_ASSERT_CYC = RST_ASSERT_MS * CYC_PER_MS;
  localparam int unsigned POWER_UP_CYC   = POWER_UP_MS * CYC_PER_MS;
  localparam int unsigned CNT_W          = 32;
  localparam int unsigned SYNC_STAGES    = 2;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_POWER_UP,
    ST_ON,
    ST_RESTART
  } mod_state_e;

  typedef enum logic [2:0] {
    HS_IDLE,
    HS_PULL_ON,
    HS_PULL_RST,
    HS_WAIT_READY
  } host_state_e;

endpackage : por_seq_pkg

// ===== por_link_if.sv
`timescale 1ns/1ps
// Purpose: open-drain control lines between host and module
// Assumes: pull-ups resolve released lines high
// Notes:   enables are active low, a low enable pulls the line to ground
interface por_link_if;
  logic switch_on_request_n_oe_n;
  logic reset_request_n_oe_n;
  logic switch_on_request_n;
  logic reset_request_n;
  logic module_on_indicator;

  // internal pull-ups: a released line reads high
  assign switch_on_request_n = switch_on_request_n_oe_n;
  assign reset_request_n     = reset_request_n_oe_n;

  modport device (
    input  switch_on_request_n,
    input  reset_request_n,
    output module_on_indicator
  );

  modport host (
    output switch_on_request_n_oe_n,
    output reset_request_n_oe_n,
    input  switch_on_request_n,
    input  reset_request_n,
    input  module_on_indicator
  );
endinterface : por_link_if

// ===== low_width_meter.sv
`timescale 1ns/1ps
// Purpose: synchronise an active-low request and report when it has stayed low long enough
// Assumes: input may be asynchronous to clk
// Notes:   accepted pulses once per low period; fall pulses on the synchronised falling edge
module low_width_meter #(
  parameter int unsigned MIN_CYC = 1
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // request line
  input  wire logic req_n,
  // results
  output logic      low,
  output logic      fall,
  output logic      accepted
);

  initial begin
    if (MIN_CYC < 1 || MIN_CYC >= 2**(por_seq_pkg::CNT_W - 1))
      $error("low_width_meter: MIN_CYC out of range");
  end

  typedef struct packed {
    logic                          s1;
    logic                          s2;
    logic                          prev;
    logic [por_seq_pkg::CNT_W-1:0] cnt;
    logic                          done;
    logic                          acc;
  } meter_s;

  meter_s st_ff;
  meter_s nxt_st;

  always_comb begin
    nxt_st      = st_ff;
    nxt_st.s1   = req_n;
    nxt_st.s2   = st_ff.s1;
    nxt_st.prev = st_ff.s2;
    nxt_st.acc  = 1'b0;
    if (st_ff.s2) begin
      nxt_st.cnt  = '0;
      nxt_st.done = 1'b0;
    end else if (!st_ff.done) begin
      nxt_st.cnt = st_ff.cnt + 1'b1;
      if (st_ff.cnt + 1'b1 >= por_seq_pkg::CNT_W'(MIN_CYC)) begin
        nxt_st.done = 1'b1;
        nxt_st.acc  = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '{s1: 1'b1, s2: 1'b1, prev: 1'b1, cnt: '0, done: 1'b0, acc: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign low      = ~st_ff.s2;
  assign fall     = st_ff.prev & ~st_ff.s2;
  assign accepted = st_ff.acc;

endmodule : low_width_meter

// ===== por_host.sv
`timescale 1ns/1ps
// Purpose: host-side driver of the open-drain switch-on and reset lines
// Assumes: commands are one-cycle pulses
// Notes:   lines are only ever pulled low or released
module por_host #(
  parameter int unsigned ON_ASSERT_CYC  = por_seq_pkg::ON_ASSERT_CYC,
  parameter int unsigned RST_ASSERT_CYC = por_seq_pkg::RST_ASSERT_CYC,
  parameter int unsigned POWER_UP_CYC   = por_seq_pkg::POWER_UP_CYC
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // link
  por_link_if.host link,
  // user commands
  input  wire logic power_on_cmd,
  input  wire logic reset_cmd,
  input  wire logic keep_on_low,
  // status
  output logic      busy,
  output logic      module_usable
);

  initial begin
    if (ON_ASSERT_CYC < 1 || RST_ASSERT_CYC < 1 || POWER_UP_CYC <= ON_ASSERT_CYC)
      $error("por_host: parameters out of range");
  end

  typedef struct packed {
    por_seq_pkg::host_state_e      state;
    logic [por_seq_pkg::CNT_W-1:0] cnt;
    logic                          on_oe_n;
    logic                          rst_oe_n;
    logic                          hold_on;
    logic                          usable;
  } host_s;

  host_s st_ff;
  host_s nxt_st;

  always_comb begin
    nxt_st     = st_ff;
    nxt_st.cnt = st_ff.cnt + 1'b1;
    unique case (st_ff.state)
      por_seq_pkg::HS_IDLE: begin
        nxt_st.cnt = '0;
        if (power_on_cmd) begin
          nxt_st.state   = por_seq_pkg::HS_PULL_ON;
          nxt_st.on_oe_n = 1'b0;
          nxt_st.usable  = 1'b0;
        end else if (reset_cmd) begin
          nxt_st.state    = por_seq_pkg::HS_PULL_RST;
          nxt_st.rst_oe_n = 1'b0;
          nxt_st.hold_on  = keep_on_low;
          nxt_st.on_oe_n  = ~keep_on_low;
          nxt_st.usable   = 1'b0;
        end
      end
      por_seq_pkg::HS_PULL_ON: begin
        if (st_ff.cnt >= por_seq_pkg::CNT_W'(ON_ASSERT_CYC)) begin
          nxt_st.on_oe_n = 1'b1;
          nxt_st.state   = por_seq_pkg::HS_WAIT_READY;
        end
      end
      por_seq_pkg::HS_PULL_RST: begin
        // four spare cycles cover the device's input synchroniser
        if (st_ff.cnt >= por_seq_pkg::CNT_W'(RST_ASSERT_CYC + 4)) begin
          nxt_st.rst_oe_n = 1'b1;
          nxt_st.on_oe_n  = 1'b1;
          nxt_st.state    = st_ff.hold_on ? por_seq_pkg::HS_WAIT_READY
                                          : por_seq_pkg::HS_IDLE;
        end
      end
      por_seq_pkg::HS_WAIT_READY: begin
        if (st_ff.cnt >= por_seq_pkg::CNT_W'(POWER_UP_CYC + 4) && link.module_on_indicator) begin
          nxt_st.usable = 1'b1;
          nxt_st.state  = por_seq_pkg::HS_IDLE;
        end
      end
      default: nxt_st.state = por_seq_pkg::HS_IDLE;
    endcase
    if (!link.module_on_indicator) begin
      nxt_st.usable = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '{state: por_seq_pkg::HS_IDLE, cnt: '0, on_oe_n: 1'b1, rst_oe_n: 1'b1,
                 hold_on: 1'b0, usable: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign link.switch_on_request_n_oe_n = st_ff.on_oe_n;
  assign link.reset_request_n_oe_n     = st_ff.rst_oe_n;
  assign busy                          = (st_ff.state != por_seq_pkg::HS_IDLE);
  assign module_usable                 = st_ff.usable;

endmodule : por_host

// ===== power_on_reset_sequencer_properties.sv
// Purpose: wire-level checks on the switch-on, reset and indicator lines
// Assumes: the watched module never sees its power-off command
// Notes:   low runs are measured in helper logic; counts arrive as parameters
`timescale 1ns/1ps
module power_on_reset_sequencer_properties #(
  parameter int unsigned ON_ASSERT_CYC  = 25,
  parameter int unsigned RST_ASSERT_CYC = 20,
  parameter int unsigned POWER_UP_CYC   = 200
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // link
  input wire logic switch_on_request_n_oe_n,
  input wire logic reset_request_n_oe_n,
  input wire logic switch_on_request_n,
  input wire logic reset_request_n,
  input wire logic module_on_indicator
);
  // ****************
  // low-run tracking
  // ****************
  typedef struct packed {
    logic [15:0] on_run;
    logic [15:0] on_len;
    logic [15:0] rst_run;
    logic [15:0] rst_len;
  } run_s;
  run_s cnt_ff;
  run_s nxt_cnt;

  // len keeps the last run after release, so late acceptance still sees it
  always_comb begin
    nxt_cnt         = cnt_ff;
    nxt_cnt.on_run  = switch_on_request_n ? 16'h0 : cnt_ff.on_run + 16'h1;
    nxt_cnt.rst_run = reset_request_n ? 16'h0 : cnt_ff.rst_run + 16'h1;
    if (!switch_on_request_n) nxt_cnt.on_len = cnt_ff.on_run + 16'h1;
    if (!reset_request_n) nxt_cnt.rst_len = cnt_ff.rst_run + 16'h1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cnt_ff <= '0;
    else cnt_ff <= nxt_cnt;
  end

  // ****************
  // properties
  // ****************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // a restart stays dark for the power-up period less the reset width;
  // this bound only suits short simulation counts
  localparam int BACK_MAX = POWER_UP_CYC + 8;

  sequence s_back_on;
    ##[1:BACK_MAX] module_on_indicator;
  endsequence
  sequence s_stay_off;
    ##1 !module_on_indicator [*8];
  endsequence
  sequence s_wipe_dip;
    ##1 !module_on_indicator [*8] ##1 !module_on_indicator [*8];
  endsequence

  chk_on_pullup: assert property (switch_on_request_n == switch_on_request_n_oe_n)
    else $error("switch-on line not at its pulled level");
  chk_on_hold_width: assert property ($rose(switch_on_request_n_oe_n) |-> cnt_ff.on_len >= ON_ASSERT_CYC)
    else $error("switch-on released too early");
  chk_rst_hold_width: assert property ($rose(reset_request_n_oe_n) |-> cnt_ff.rst_len >= RST_ASSERT_CYC)
    else $error("reset released too early");
  chk_on_needs_request: assert property ($rose(module_on_indicator) |->
    cnt_ff.on_len >= ON_ASSERT_CYC || cnt_ff.rst_len >= RST_ASSERT_CYC)
    else $error("indicator rose without a full request");
  chk_off_needs_reset: assert property ($fell(module_on_indicator) |-> cnt_ff.rst_len >= RST_ASSERT_CYC)
    else $error("indicator fell without a full reset");
  chk_restart_back_on: assert property ($fell(module_on_indicator) && !switch_on_request_n |-> s_back_on)
    else $error("restart did not come back on");
  chk_wipe_dip: assert property ($fell(module_on_indicator) && !switch_on_request_n |-> s_wipe_dip)
    else $error("restart dip shorter than the wipe");
  chk_power_off_stays: assert property ($fell(module_on_indicator) && switch_on_request_n |-> s_stay_off)
    else $error("module came back after power-off reset");
endmodule : power_on_reset_sequencer_properties

// ===== power_on_reset_sequencer_test.sv
// Purpose: host and module pair run end to end, plus a bench-driven second module
// Assumes: shortened counts 25, 20 and 200 cycles
// Notes:   ready changes are matched against a queue of notes
`timescale 1ns/1ps
module power_on_reset_sequencer_test;
  localparam int unsigned ON_C  = 25;
  localparam int unsigned RST_C = 20;
  localparam int unsigned PU_C  = 200;
  localparam int          LIMIT = 5000;
  typedef struct {bit dev; logic val; int earliest;} note_s;
  logic       clk = 1'b0, rst_n = 1'b0, power_on_cmd = 1'b0, reset_cmd = 1'b0;
  logic       keep_on_low = 1'b0, pwr_off_2 = 1'b0, ready_1, ready_2, wipe_1, busy, usable;
  logic [1:0] rdy, ready_prev = 2'b00;
  int         cyc = 0, mismatches = 0, checks = 0, wipe_cnt = 0;
  note_s      notes[$];
  note_s      n;

  por_link_if por_link_if_inst();
  por_link_if far_link();
  always #2.5 clk = ~clk;
  assign rdy = {ready_2, ready_1};

  por_host #(.ON_ASSERT_CYC(ON_C), .RST_ASSERT_CYC(RST_C), .POWER_UP_CYC(PU_C)) por_host_inst (
    .clk(clk), .rst_n(rst_n), .link(por_link_if_inst), .power_on_cmd(power_on_cmd),
    .reset_cmd(reset_cmd), .keep_on_low(keep_on_low), .busy(busy), .module_usable(usable));
  por_device #(.ON_ASSERT_CYC(ON_C), .RST_ASSERT_CYC(RST_C), .POWER_UP_CYC(PU_C)) por_device_inst (
    .clk(clk), .rst_n(rst_n), .link(por_link_if_inst), .software_power_off_command(1'b0),
    .module_ready(ready_1), .wipe_busy(wipe_1));
  por_device #(.ON_ASSERT_CYC(ON_C), .RST_ASSERT_CYC(RST_C), .POWER_UP_CYC(PU_C)) por_device_2_inst (
    .clk(clk), .rst_n(rst_n), .link(far_link), .software_power_off_command(pwr_off_2),
    .module_ready(ready_2), .wipe_busy());
  power_on_reset_sequencer_properties #(.ON_ASSERT_CYC(ON_C), .RST_ASSERT_CYC(RST_C),
    .POWER_UP_CYC(PU_C)) props (
    .clk(clk), .rst_n(rst_n),
    .switch_on_request_n_oe_n(por_link_if_inst.switch_on_request_n_oe_n),
    .reset_request_n_oe_n(por_link_if_inst.reset_request_n_oe_n),
    .switch_on_request_n(por_link_if_inst.switch_on_request_n),
    .reset_request_n(por_link_if_inst.reset_request_n),
    .module_on_indicator(por_link_if_inst.module_on_indicator));

  // ****************
  // tasks
  // ****************
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize

  task automatic host_cmd(bit rst, bit keep);
    @(posedge clk);
    keep_on_low <= keep;
    if (rst) reset_cmd <= 1'b1;
    else power_on_cmd <= 1'b1;
    @(posedge clk);
    reset_cmd    <= 1'b0;
    power_on_cmd <= 1'b0;
  endtask : host_cmd

  task automatic wait_done(bit dev, logic want);
    int k = 0;
    repeat (3) @(posedge clk);
    while ((busy === 1'b1 || rdy[dev] !== want) && k < 3 * PU_C) begin
      @(posedge clk);
      k++;
    end
  endtask : wait_done

  // the bench stands in for a host on the second link: pull low, then release
  task automatic far_pulse(bit rst_line, int len);
    @(posedge clk);
    if (rst_line) far_link.reset_request_n_oe_n <= 1'b0;
    else far_link.switch_on_request_n_oe_n <= 1'b0;
    repeat (len) @(posedge clk);
    far_link.reset_request_n_oe_n     <= 1'b1;
    far_link.switch_on_request_n_oe_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask : far_pulse

  // ****************
  // monitor and stimulus
  // ****************
  // a hang counts as a mismatch, so it ends on a failing verdict through the same summary
  always @(posedge clk) begin
    if (cyc == LIMIT) begin
      mismatches++;
      summarize();
    end
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (wipe_1 === 1'b1) wipe_cnt <= wipe_cnt + 1;
    for (int d = 0; d < 2; d++) begin
      if (rst_n && rdy[d] !== ready_prev[d]) begin
        if (notes.size() == 0) check("unexpected ready change", rdy[d], ready_prev[d]);
        else begin
          n = notes.pop_front();
          check("ready device", d, n.dev);
          check("ready level", rdy[d], n.val);
          check("ready not too early", cyc >= n.earliest, 1'b1);
        end
      end
    end
    ready_prev <= rdy;
  end

  initial begin
    far_link.switch_on_request_n_oe_n = 1'b1;
    far_link.reset_request_n_oe_n     = 1'b1;
    void'($urandom(41));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (20) @(posedge clk);
    check("idle stays off", far_link.module_on_indicator, 1'b0);
    notes.push_back('{1'b0, 1'b1, cyc + PU_C});
    host_cmd(0, 0);
    wait_done(0, 1'b1);
    check("usable", usable, 1'b1);
    check("indicator on", por_link_if_inst.module_on_indicator, 1'b1);
    host_cmd(0, 0);
    wait_done(0, 1'b1);
    check("still on", ready_1, 1'b1);
    notes.push_back('{1'b0, 1'b0, 0});
    notes.push_back('{1'b0, 1'b1, cyc + PU_C});
    host_cmd(1, 1);
    wait_done(0, 1'b1);
    check("wipe length", wipe_cnt >= 16, 1'b1);
    notes.push_back('{1'b0, 1'b0, 0});
    host_cmd(1, 0);
    repeat (PU_C + 40) @(posedge clk);
    check("off after reset", por_link_if_inst.module_on_indicator, 1'b0);
    // short requests on the second link must be refused
    repeat (4) far_pulse(0, $urandom_range(ON_C - 3, 1));
    check("short on refused", far_link.module_on_indicator, 1'b0);
    notes.push_back('{1'b1, 1'b1, cyc + PU_C});
    far_pulse(0, ON_C + 4);
    wait_done(1, 1'b1);
    far_pulse(1, RST_C - 4);
    check("short reset refused", ready_2, 1'b1);
    notes.push_back('{1'b1, 1'b0, 0});
    @(posedge clk) pwr_off_2 <= 1'b1;
    @(posedge clk) pwr_off_2 <= 1'b0;
    wait_done(1, 1'b0);
    check("power off", far_link.module_on_indicator, 1'b0);
    check("notes drained", notes.size(), 0);
    summarize();
  end
endmodule : power_on_reset_sequencer_test
